// ===== logic/trig_aux_pkg.sv
// Summary of operation
// - start=d, stop=d+1 gives pulse d cycles later
// - gate feeds trigger only when enabled in mask
// - sources ORed, enabled gates ANDed with result
// - precursor two aligns samples with lagging gates
// - retrigger holds count at 1 while asserted; open if start <= 1 < stop
// - period is one plus M plus random count
// - one timestamp packet per firing cycle
// - timestamp packet is sixteen bytes, event time
// - packet carries source levels, minus period monitor
// - lookup table replaces sample, 1024 entries
// - linearity correction applied before table lookup
// - separate master/slave sync delay, role selects
// - sync delay accepts 0 through 31 only
// - gate window opens at start, closes stop, invertible
// - retrigger during window restarts window timing
package trig_aux_pkg;
  localparam int GATES = 4;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] GATE_TIME_OFS = 8'h10;
  localparam logic [7:0] GATE_OPT_OFS  = 8'h20;
  localparam logic [7:0] TB_CFG_OFS    = 8'h30;
  localparam logic [7:0] FG_M_OFS      = 8'h34;
  localparam logic [7:0] FG_N_OFS      = 8'h38;
  localparam logic [7:0] TS_MASK_OFS   = 8'h3c;
  localparam logic [7:0] LUT_IDX_OFS   = 8'h40;
  localparam logic [7:0] LUT_DATA_OFS  = 8'h44;
  localparam logic [7:0] INL_OFS       = 8'h48;
  localparam logic [7:0] SYNC_M_OFS    = 8'h4c;
  localparam logic [7:0] SYNC_S_OFS    = 8'h50;
  localparam logic [7:0] REG_STRIDE    = 8'h04;
  localparam int OPT_RETRIG = 8;
  localparam int OPT_NEGATE = 9;
  localparam int TB_AND_LSB = 16;
  localparam int TB_PRE_LSB = 20;
  localparam logic [1:0] PRECURSOR_RST = 2'h2;
  localparam logic [4:0] SYNC_MAX = 5'h1f;
  localparam int PMON_BIT = 4;
  localparam int LUT_WORDS = 1024;
  localparam logic [31:0] LFSR_TAPS = 32'h80200003;
  localparam logic [31:0] LFSR_SEED = 32'h00000001;
  localparam logic [31:0] PKT_INFO  = 32'h00000000;

  typedef struct packed {
    logic tsEn;
    logic fgEn;
    logic isMaster;
    logic lutEn;
  } ctrl_s;

  typedef struct packed {
    logic [63:0] stamp;
    logic [31:0] levels;
    logic [31:0] info;
  } ts_packet_s;
endpackage

// ===== logic/trigger_aux_logic.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_reg];

  // storage has no reset, pointers guard it
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr_reg] <= inData;
  end

  // pointers wrap, depth is a power of two
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count     <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

module trigger_aux_logic #(
  parameter int CW = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] trigIn,
  input  wire logic [5:0]  addTrig,
  input  wire logic        periodMon,
  input  wire logic [9:0]  adcSample,
  output logic [15:0]      sampleOut,
  output logic             trigOut,
  output logic [4:0]       syncDelay,
  output logic             pktValid,
  input  wire logic        pktReady,
  output logic [127:0]     pktData
);
  localparam int G = trig_aux_pkg::GATES;
  trig_aux_pkg::ctrl_s ctrl_reg;
  logic [CW-1:0] gStart_reg [G];
  logic [CW-1:0] gStop_reg  [G];
  logic [9:0]    gOpt_reg   [G];
  logic [CW-1:0] gCnt_reg   [G];
  logic [G-1:0]  gRun_reg;
  logic [G-1:0]  gTrig;
  logic [G-1:0]  gateOut;
  logic [21:0]   tbCfg_reg;
  logic [31:0]   fgM_reg;
  logic [4:0]    fgN_reg;
  logic [31:0]   tsMask_reg;
  logic [9:0]    lutIdx_reg;
  logic [10:0]   inl_reg;
  logic [4:0]    syncM_reg;
  logic [4:0]    syncS_reg;
  logic [15:0]   drops_reg;
  logic [15:0]   lutMem [trig_aux_pkg::LUT_WORDS];
  logic          wrEn;
  logic          setup;
  logic          hit;
  logic [31:0]   rdNext;
  logic [5:0]    fifoCnt;

  // apb: read data caught in setup, zero-wait access
  assign wrEn    = psel && penable && pwrite;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // address decode and read mux
  always_comb
  begin
    hit    = 1'b1;
    rdNext = 32'h0;
    case (paddr)
      trig_aux_pkg::CTRL_OFS:     rdNext = {28'h0, ctrl_reg};
      trig_aux_pkg::STATUS_OFS:   rdNext = {drops_reg, 10'h0, fifoCnt};
      trig_aux_pkg::TB_CFG_OFS:   rdNext = {10'h0, tbCfg_reg};
      trig_aux_pkg::FG_M_OFS:     rdNext = fgM_reg;
      trig_aux_pkg::FG_N_OFS:     rdNext = {27'h0, fgN_reg};
      trig_aux_pkg::TS_MASK_OFS:  rdNext = tsMask_reg;
      trig_aux_pkg::LUT_IDX_OFS:  rdNext = {22'h0, lutIdx_reg};
      trig_aux_pkg::LUT_DATA_OFS: rdNext = {16'h0, lutMem[lutIdx_reg]};
      trig_aux_pkg::INL_OFS:      rdNext = {21'h0, inl_reg};
      trig_aux_pkg::SYNC_M_OFS:   rdNext = {27'h0, syncM_reg};
      trig_aux_pkg::SYNC_S_OFS:   rdNext = {27'h0, syncS_reg};
      default:
      begin
        hit = 1'b0;
        for (int g = 0; g < G; g++)
        begin
          if (paddr == trig_aux_pkg::GATE_TIME_OFS
                       + 8'(g) * trig_aux_pkg::REG_STRIDE)
          begin
            hit    = 1'b1;
            rdNext = {gStop_reg[g], gStart_reg[g]};
          end
          if (paddr == trig_aux_pkg::GATE_OPT_OFS
                       + 8'(g) * trig_aux_pkg::REG_STRIDE)
          begin
            hit    = 1'b1;
            rdNext = {22'h0, gOpt_reg[g]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0;
    else if (setup && !pwrite)
      prdata <= rdNext;
  end

  // global registers; sync values above 31 are dropped
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg   <= '0;
      tbCfg_reg  <= {trig_aux_pkg::PRECURSOR_RST, 20'h0};
      fgM_reg    <= 32'h0;
      fgN_reg    <= 5'h0;
      tsMask_reg <= 32'h0;
      inl_reg    <= 11'h0;
      syncM_reg  <= 5'h0;
      syncS_reg  <= 5'h0;
    end
    else if (wrEn)
    begin
      case (paddr)
        trig_aux_pkg::CTRL_OFS:    ctrl_reg   <= pwdata[3:0];
        trig_aux_pkg::TB_CFG_OFS:  tbCfg_reg  <= pwdata[21:0];
        trig_aux_pkg::FG_M_OFS:    fgM_reg    <= pwdata;
        trig_aux_pkg::FG_N_OFS:    fgN_reg    <= pwdata[4:0];
        trig_aux_pkg::TS_MASK_OFS: tsMask_reg <= pwdata;
        trig_aux_pkg::INL_OFS:     inl_reg    <= pwdata[10:0];
        trig_aux_pkg::SYNC_M_OFS:
          if (pwdata <= 32'(trig_aux_pkg::SYNC_MAX))
            syncM_reg <= pwdata[4:0];
        trig_aux_pkg::SYNC_S_OFS:
          if (pwdata <= 32'(trig_aux_pkg::SYNC_MAX))
            syncS_reg <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // role picks which delay drives the sync tap
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      syncDelay <= 5'h0;
    else
      syncDelay <= ctrl_reg.isMaster ? syncM_reg : syncS_reg;
  end

  // function generator: countdown reloaded with 1+M+r
  logic [31:0] lfsr_reg;
  logic [31:0] fgCnt_reg;
  logic [31:0] rndNext;
  logic        funcPulse;
  assign rndNext = (lfsr_reg & ((32'h1 << fgN_reg) - 32'h1)) + 32'h1;
  assign funcPulse = ctrl_reg.fgEn && (fgCnt_reg == 32'h1);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      lfsr_reg <= trig_aux_pkg::LFSR_SEED;
    else if (lfsr_reg[0]) // free-running galois lfsr
      lfsr_reg <= (lfsr_reg >> 1) ^ trig_aux_pkg::LFSR_TAPS;
    else
      lfsr_reg <= lfsr_reg >> 1;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      fgCnt_reg <= 32'h0;
    else if (!ctrl_reg.fgEn || fgCnt_reg <= 32'h1)
      fgCnt_reg <= 32'h1 + fgM_reg + rndNext;
    else
      fgCnt_reg <= fgCnt_reg - 32'h1;
  end

  // gating blocks; sources are trigger inputs and generator
  logic [7:0] gSrc;
  assign gSrc = {funcPulse, trigIn[6:0]};

  for (genvar g = 0; g < G; g++)
  begin : gate
    logic [7:0] tOfs;
    logic [7:0] oOfs;
    assign tOfs = trig_aux_pkg::GATE_TIME_OFS
                  + 8'(g) * trig_aux_pkg::REG_STRIDE;
    assign oOfs = trig_aux_pkg::GATE_OPT_OFS
                  + 8'(g) * trig_aux_pkg::REG_STRIDE;
    assign gTrig[g] = |(gSrc & gOpt_reg[g][7:0]);
    // window from start count up to stop count
    assign gateOut[g] = (gRun_reg[g] && gCnt_reg[g] >= gStart_reg[g]
                         && gCnt_reg[g] < gStop_reg[g])
                        ^ gOpt_reg[g][trig_aux_pkg::OPT_NEGATE];

    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        gStart_reg[g] <= '0;
        gStop_reg[g]  <= '0;
        gOpt_reg[g]   <= '0;
      end
      else if (wrEn && paddr == tOfs)
      begin
        gStart_reg[g] <= pwdata[CW-1:0];
        gStop_reg[g]  <= pwdata[CW+15:16];
      end
      else if (wrEn && paddr == oOfs)
        gOpt_reg[g] <= pwdata[9:0];
    end

    // without retrigger a running window is dead time
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        gRun_reg[g] <= 1'b0;
        gCnt_reg[g] <= '0;
      end
      else if (gTrig[g] && (!gRun_reg[g]
               || gOpt_reg[g][trig_aux_pkg::OPT_RETRIG]))
      begin
        gRun_reg[g] <= 1'b1;
        gCnt_reg[g] <= CW'(1);
      end
      else if (gRun_reg[g] && gCnt_reg[g] >= gStop_reg[g])
        gRun_reg[g] <= 1'b0;
      else if (gRun_reg[g])
        gCnt_reg[g] <= gCnt_reg[g] + 1'b1;
    end
  end

  // trigger block: bit 0 of the source mask is constant true
  logic [15:0] tbSrc;
  logic        srcOr;
  logic        andOk;
  assign tbSrc = {trigIn[13:0], funcPulse, 1'b1};
  assign srcOr = |(tbSrc & tbCfg_reg[15:0]);
  assign andOk = &(gateOut | ~tbCfg_reg[trig_aux_pkg::TB_AND_LSB +: G]);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      trigOut <= 1'b0;
    else
      trigOut <= srcOr && andOk;
  end

  // sample path: linearity fix, clamp, then table
  logic [11:0] corrSum;
  logic [9:0]  idx_reg;
  logic [15:0] lutData_reg;
  logic [15:0] dly_reg [4];
  assign corrSum = {2'h0, adcSample} + {inl_reg[10], inl_reg};

  always_ff @(posedge ref_clk)
  begin
    if (wrEn && paddr == trig_aux_pkg::LUT_DATA_OFS)
      lutMem[lutIdx_reg] <= pwdata[15:0];
  end

  // index auto-increments so a table loads in one burst
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      lutIdx_reg <= 10'h0;
    else if (wrEn && paddr == trig_aux_pkg::LUT_IDX_OFS)
      lutIdx_reg <= pwdata[9:0];
    else if (wrEn && paddr == trig_aux_pkg::LUT_DATA_OFS)
      lutIdx_reg <= lutIdx_reg + 10'h1;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      idx_reg     <= 10'h0;
      lutData_reg <= 16'h0;
      for (int i = 0; i < 4; i++)
        dly_reg[i] <= 16'h0;
      sampleOut   <= 16'h0;
    end
    else
    begin
      if (corrSum[11])
        idx_reg <= 10'h0;
      else if (corrSum[10])
        idx_reg <= 10'h3ff;
      else
        idx_reg <= corrSum[9:0];
      lutData_reg <= ctrl_reg.lutEn ? lutMem[idx_reg]
                                    : {6'h0, idx_reg};
      dly_reg[0] <= lutData_reg;
      for (int i = 1; i < 4; i++)
        dly_reg[i] <= dly_reg[i-1];
      // precursor lets samples line up with late gates
      sampleOut <= dly_reg[tbCfg_reg[trig_aux_pkg::TB_PRE_LSB +: 2]];
    end
  end

  // timestamp channel: one packet per firing cycle
  logic [31:0] levels;
  logic [63:0] stamp_reg;
  logic        tsFire;
  logic        fifoInReady;
  trig_aux_pkg::ts_packet_s pkt;
  assign levels = {trigIn, addTrig, gateOut, funcPulse, 1'b0, 4'h0};
  assign tsFire = ctrl_reg.tsEn && |(tsMask_reg & levels);
  assign pkt = '{stamp: stamp_reg, levels: levels,
                 info: trig_aux_pkg::PKT_INFO};

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stamp_reg <= 64'h0;
      drops_reg <= 16'h0;
    end
    else
    begin
      stamp_reg <= stamp_reg + 64'h1;
      // a full buffer loses the event, counted saturating
      if (tsFire && !fifoInReady && drops_reg != 16'hffff)
        drops_reg <= drops_reg + 16'h1;
    end
  end

  sample_fifo #(.WIDTH(128), .DEPTH(32)) pktFifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inValid  (tsFire),
    .inReady  (fifoInReady),
    .inData   (pkt),
    .outValid (pktValid),
    .outReady (pktReady),
    .outData  (pktData),
    .count    (fifoCnt)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [31:0] since_reg;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      since_reg <= 32'h0;
    else
      since_reg <= funcPulse ? 32'h1 : since_reg + 32'h1;
  end

  AST_GATE_OPEN: assert property (
    $rose(gRun_reg[0] && gCnt_reg[0] == gStart_reg[0])
    && !gOpt_reg[0][trig_aux_pkg::OPT_NEGATE]
    && gStop_reg[0] == gStart_reg[0] + 1'b1 && gStart_reg[0] != '0
    |-> gateOut[0] ##1 (!gateOut[0] || gCnt_reg[0] == CW'(1)))
    else $error("gate pulse not one cycle");
  AST_AND_BLOCK: assert property (
    tbCfg_reg[trig_aux_pkg::TB_AND_LSB] && !gateOut[0] |=> !trigOut)
    else $error("disabled gate let trigger through");
  AST_OR_COMB: assert property (
    |(trigIn[13:0] & tbCfg_reg[15:2])
    && tbCfg_reg[trig_aux_pkg::TB_AND_LSB +: G] == '0 |=> trigOut)
    else $error("ored source did not trigger");
  AST_PRECURSOR: assert property (
    tbCfg_reg[trig_aux_pkg::TB_PRE_LSB +: 2] == 2'h2
    && $past(tbCfg_reg[trig_aux_pkg::TB_PRE_LSB +: 2]) == 2'h2
    |-> sampleOut == $past(lutData_reg, 4))
    else $error("precursor alignment wrong");
  AST_RETRIG: assert property (
    gTrig[1] && gRun_reg[1] && gOpt_reg[1][trig_aux_pkg::OPT_RETRIG]
    |=> gRun_reg[1] && gCnt_reg[1] == CW'(1))
    else $error("retrigger did not restart window");
  AST_FG_PERIOD: assert property (
    funcPulse && $past(ctrl_reg.fgEn, 2) && since_reg > 32'h1
    |-> since_reg >= fgM_reg + 32'h2)
    else $error("generator period too short");
  AST_ONE_PKT: assert property (
    tsFire && fifoInReady && !(pktValid && pktReady)
    |=> fifoCnt == $past(fifoCnt) + 6'h1)
    else $error("timestamp packet count wrong");
  AST_PMON_OUT: assert property (
    tsFire |-> !pkt.levels[trig_aux_pkg::PMON_BIT]
    && pkt.levels[31:16] == trigIn)
    else $error("packet levels wrong");
  AST_SYNC_ROLE: assert property (
    ##1 $stable(ctrl_reg) |-> syncDelay == (ctrl_reg.isMaster
      ? $past(syncM_reg) : $past(syncS_reg)))
    else $error("sync delay not from role");
  AST_SYNC_RANGE: assert property (
    wrEn && paddr == trig_aux_pkg::SYNC_M_OFS && pwdata > 32'h1f
    |=> $stable(syncM_reg))
    else $error("sync delay above 31 accepted");
  COV_PULSE: cover property ($rose(gateOut[0]) ##1 !gateOut[0]);
  COV_PKT:   cover property (tsFire && fifoInReady);
  COV_FG:    cover property (funcPulse ##[1:64] funcPulse);
  COV_AND:   cover property (&gateOut && trigOut);
endmodule

// ===== test/stream_partner_model.sv
`timescale 1ns/1ps
module stream_partner_model (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         stall,
  input  wire logic [9:0]   sampleSet,
  output logic [9:0]        adcSample,
  input  wire logic         pktValid,
  input  wire logic [127:0] pktData,
  output logic              pktReady
);
  logic [127:0] got[$];

  // adc stream: one new sample each cycle, like the converter
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      adcSample <= 10'h000;
    else
      adcSample <= sampleSet;

  // sink stalls on command so the buffer can be filled
  assign pktReady = !stall;

  // keep every popped packet for the bench to judge
  always @(posedge ref_clk)
    if (resetn && pktValid && pktReady)
      got.push_back(pktData);
endmodule

// ===== test/digitizer_trigger_aux_logic_tb.sv
`timescale 1ns/1ps
module digitizer_trigger_aux_logic_tb;
  logic         ref_clk;
  logic         resetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  trigIn;
  logic [5:0]   addTrig;
  logic         periodMon;
  logic [9:0]   adcSample;
  logic [9:0]   sampleSet;
  logic [15:0]  sampleOut;
  logic         trigOut;
  logic [4:0]   syncDelay;
  logic         pktValid;
  logic         pktReady;
  logic [127:0] pktData;
  logic         stall;
  int           fail_count;
  int           compares;

  trigger_aux_logic uut (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
    .addTrig(addTrig), .periodMon(periodMon), .adcSample(adcSample),
    .sampleOut(sampleOut), .trigOut(trigOut), .syncDelay(syncDelay),
    .pktValid(pktValid), .pktReady(pktReady), .pktData(pktData)
  );

  stream_partner_model partner (
    .ref_clk(ref_clk), .resetn(resetn), .stall(stall),
    .sampleSet(sampleSet), .adcSample(adcSample), .pktValid(pktValid),
    .pktData(pktData), .pktReady(pktReady)
  );

  // free-running clock, 8 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    fail_count++;
    final_report();
  endtask

  // apb transfer; the wait on pready is bounded, not assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      timed_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // cycles until trigOut is seen high, bounded
  task automatic wait_trig(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (trigOut !== 1'b1 && n < 200);
    if (n >= 200)
      timed_out();
  endtask

  task automatic test_regs();
    logic [31:0] q;
    logic        e;
    rd(trig_aux_pkg::STATUS_OFS, q);
    chk(q, 32'h0);
    apb(1'b0, 8'h7c, 32'h0, q, e);
    chk(e, 1'b1);
    wr(trig_aux_pkg::SYNC_M_OFS, 32'h7);
    wr(trig_aux_pkg::SYNC_S_OFS, 32'h14);
    wr(trig_aux_pkg::CTRL_OFS, 32'h2);
    cycles(3);
    chk(syncDelay, 5'h07);
    wr(trig_aux_pkg::SYNC_M_OFS, 32'h20);
    rd(trig_aux_pkg::SYNC_M_OFS, q);
    chk(q, 32'h7);
    wr(trig_aux_pkg::SYNC_S_OFS, 32'h1f);
    wr(trig_aux_pkg::CTRL_OFS, 32'h0);
    cycles(3);
    chk(syncDelay, 5'h1f);
  endtask

  // trigger once, return delay to the gated pulse
  task automatic pulse_lat(input int d, output int lat);
    wr(trig_aux_pkg::GATE_TIME_OFS, {16'(d + 1), 16'(d)});
    @(posedge ref_clk);
    trigIn <= 16'h0001;
    @(posedge ref_clk);
    trigIn <= 16'h0000;
    wait_trig(lat);
    @(posedge ref_clk);
    chk(trigOut, 1'b0);
  endtask

  task automatic test_gate();
    int l3;
    int l6;
    wr(trig_aux_pkg::GATE_OPT_OFS, 32'h1);
    wr(trig_aux_pkg::TB_CFG_OFS, 32'h0021_0001);
    pulse_lat(3, l3);
    pulse_lat(6, l6);
    chk(l6 - l3, 3);
    // sources ORed, then a closed gate blocks them
    wr(trig_aux_pkg::TB_CFG_OFS, 32'h0020_000c);
    trigIn <= 16'h0002;
    cycles(4);
    chk(trigOut, 1'b1);
    wr(trig_aux_pkg::TB_CFG_OFS, 32'h0021_000c);
    cycles(4);
    chk(trigOut, 1'b0);
    trigIn <= 16'h0000;
  endtask

  // held trigger keeps a retriggered gate open, then it closes
  task automatic test_retrig();
    wr(trig_aux_pkg::GATE_OPT_OFS + trig_aux_pkg::REG_STRIDE, 32'h0000_0102);
    wr(trig_aux_pkg::GATE_TIME_OFS + trig_aux_pkg::REG_STRIDE, 32'h0003_0001);
    wr(trig_aux_pkg::TB_CFG_OFS, 32'h0022_0001);
    trigIn <= 16'h0002;
    cycles(3);
    repeat (4)
    begin
      @(posedge ref_clk);
      chk(trigOut, 1'b1);
    end
    trigIn <= 16'h0000;
    cycles(5);
    chk(trigOut, 1'b0);
    // inverted idle gate lets the constant source through
    wr(trig_aux_pkg::GATE_OPT_OFS + trig_aux_pkg::REG_STRIDE, 32'h0000_0302);
    cycles(3);
    chk(trigOut, 1'b1);
    wr(trig_aux_pkg::GATE_OPT_OFS + trig_aux_pkg::REG_STRIDE, 32'h0);
  endtask

  task automatic test_fgen();
    int n;
    wr(trig_aux_pkg::FG_M_OFS, 32'ha);
    wr(trig_aux_pkg::FG_N_OFS, 32'h0);
    wr(trig_aux_pkg::TB_CFG_OFS, 32'h0020_0002);
    wr(trig_aux_pkg::CTRL_OFS, 32'h4);
    wait_trig(n);
    wait_trig(n);
    chk(n, 12);
    wr(trig_aux_pkg::FG_N_OFS, 32'h2);
    wait_trig(n);
    repeat (4)
    begin
      wait_trig(n);
      chk(n >= 12 && n <= 15, 1'b1);
    end
    wr(trig_aux_pkg::CTRL_OFS, 32'h0);
  endtask

  task automatic test_stamp();
    logic [31:0] q;
    int          n;
    wr(trig_aux_pkg::TS_MASK_OFS, 32'hffff_0000);
    wr(trig_aux_pkg::CTRL_OFS, 32'h8);
    stall <= 1'b1;
    periodMon <= 1'b1;
    // two sources together, then again five cycles later
    repeat (2)
    begin
      @(posedge ref_clk);
      trigIn <= 16'h0003;
      @(posedge ref_clk);
      trigIn <= 16'h0000;
      cycles(3);
    end
    rd(trig_aux_pkg::STATUS_OFS, q);
    chk(q[5:0], 6'h02);
    stall <= 1'b0;
    cycles(6);
    chk(partner.got.size(), 2);
    chk(partner.got[0][63:36], 28'h0003000);
    chk(partner.got[0][31:0], 32'h0);
    chk(partner.got[1][127:64] - partner.got[0][127:64], 5);
    // stalled sink: fill until full, two events dropped
    stall <= 1'b1;
    repeat (34)
    begin
      @(posedge ref_clk);
      trigIn <= 16'h0001;
      @(posedge ref_clk);
      trigIn <= 16'h0000;
    end
    cycles(3);
    rd(trig_aux_pkg::STATUS_OFS, q);
    chk(q, 32'h0002_0020);
    stall <= 1'b0;
    n = 0;
    while (pktValid !== 1'b0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100)
      timed_out();
    chk(partner.got.size(), 34);
    periodMon <= 1'b0;
    wr(trig_aux_pkg::CTRL_OFS, 32'h0);
  endtask

  task automatic test_lut();
    logic [31:0] q;
    wr(trig_aux_pkg::LUT_IDX_OFS, 32'h5);
    wr(trig_aux_pkg::LUT_DATA_OFS, 32'h0abc);
    wr(trig_aux_pkg::LUT_DATA_OFS, 32'h0def);
    wr(trig_aux_pkg::LUT_IDX_OFS, 32'h5);
    rd(trig_aux_pkg::LUT_DATA_OFS, q);
    chk(q[15:0], 16'h0abc);
    // sample first, so no unloaded table entry is ever looked up
    sampleSet <= 10'h005;
    wr(trig_aux_pkg::INL_OFS, 32'h0);
    wr(trig_aux_pkg::CTRL_OFS, 32'h1);
    cycles(10);
    chk(sampleOut, 16'h0abc);
    // offset applied first, so index 6 is looked up
    wr(trig_aux_pkg::INL_OFS, 32'h1);
    cycles(10);
    chk(sampleOut, 16'h0def);
  endtask

  // reset for 12 cycles, then the scenarios in turn
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trigIn = 16'h0000;
    addTrig = 6'h00;
    periodMon = 1'b0;
    sampleSet = 10'h000;
    stall = 1'b0;
    fail_count = 0;
    compares = 0;
    cycles(12);
    resetn <= 1'b1;
    test_regs();
    test_gate();
    test_retrig();
    test_fgen();
    test_stamp();
    test_lut();
    final_report();
  end
endmodule
